// ---- rtl/pss_map.svh ----
// Register offsets, field positions, opcodes and limits for the packed shift/subtract unit
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH

// Register byte offsets
`define PSS_CTRL_OFS 12'h000
`define PSS_STAT_OFS 12'h004
`define PSS_OPCNT_OFS 12'h008
`define PSS_FLTCNT_OFS 12'h00C

// Control register fields
`define PSS_CTRL_EMU 0
`define PSS_CTRL_TSW 1
`define PSS_CTRL_FPE 2
`define PSS_CTRL_PROT 3
`define PSS_CTRL_CPL_LO 4
`define PSS_CTRL_CPL_HI 5
`define PSS_CTRL_RST 6'h00
`define PSS_CPL_USER 2'h3

// Second opcode byte after the 0F escape
`define PSS_OPC_SHRW_RM 8'hD1
`define PSS_OPC_SHRD_RM 8'hD2
`define PSS_OPC_SHRQ_RM 8'hD3
`define PSS_OPC_SHRW_IMM 8'h71
`define PSS_OPC_SHRD_IMM 8'h72
`define PSS_OPC_SHRQ_IMM 8'h73
`define PSS_MODRM_SHR 3'h2
`define PSS_OPC_SUBB 8'hF8
`define PSS_OPC_SUBW 8'hF9
`define PSS_OPC_SUBD 8'hFA
`define PSS_OPC_SATB 8'hE8
`define PSS_OPC_SATW 8'hE9

// Shift count limits per lane width
`define PSS_LIM_W 64'h0000_0000_0000_000F
`define PSS_LIM_D 64'h0000_0000_0000_001F
`define PSS_LIM_Q 64'h0000_0000_0000_003F

// Saturation bounds
`define PSS_SATB_MAX 8'h7F
`define PSS_SATB_MIN 8'h80
`define PSS_SATW_MAX 16'h7FFF
`define PSS_SATW_MIN 16'h8000

// Real-mode address space and operand size
`define PSS_REAL_TOP 33'h0_0000_FFFF
`define PSS_OPND_LAST 33'h0_0000_0007
`define PSS_ALIGN_MASK 32'h0000_0007

`endif

// ---- rtl/pss_pkg.sv ----
// Types shared by the packed shift/subtract unit
`default_nettype none
package pss_pkg;

  typedef enum logic [8:0] {
    PSS_OP_NONE = 9'h000,
    PSS_OP_SHRW = 9'h001,
    PSS_OP_SHRD = 9'h002,
    PSS_OP_SHRQ = 9'h004,
    PSS_OP_SUBB = 9'h008,
    PSS_OP_SUBW = 9'h010,
    PSS_OP_SUBD = 9'h020,
    PSS_OP_SATB = 9'h040,
    PSS_OP_SATW = 9'h080,
    PSS_OP_BAD = 9'h100
  } pss_op_t;

  typedef enum logic [2:0] {
    PSS_FLT_NONE = 3'h0,
    PSS_FLT_UD = 3'h1,
    PSS_FLT_NM = 3'h2,
    PSS_FLT_MF = 3'h3,
    PSS_FLT_GP = 3'h4,
    PSS_FLT_SS = 3'h5,
    PSS_FLT_PF = 3'h6,
    PSS_FLT_AC = 3'h7
  } pss_fault_t;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [2:0] modrm_reg;
    logic [7:0] imm8;
    logic [63:0] dst;
    logic [63:0] src;
    logic src_is_mem;
    logic [31:0] mem_addr;
    logic mem_gp;
    logic mem_ss;
    logic mem_pf;
  } pss_req_t;

  typedef struct packed {
    logic valid;
    logic dst_write;
    logic [63:0] result;
    logic fault;
    pss_fault_t fault_code;
  } pss_rsp_t;

endpackage
`default_nettype wire

// ---- rtl/pss_unit.sv ----
// Packed logical right shift and packed subtract datapath with fault checks and APB control
`include "pss_map.svh"
`default_nettype none

module pss_unit (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Instruction request from decode
  input wire pss_pkg::pss_req_t I_REQ,
  // Result to register file
  output pss_pkg::pss_rsp_t O_RSP
);

  logic [5:0] ctrl;
  logic [31:0] op_count;
  logic [31:0] fault_count;
  pss_pkg::pss_fault_t last_fault;
  pss_pkg::pss_op_t op;
  logic imm_form;
  logic [63:0] count;
  logic zero_w;
  logic zero_d;
  logic zero_q;
  logic [63:0] shr_w;
  logic [63:0] shr_d;
  logic [63:0] shr_q;
  logic [63:0] sub_b;
  logic [63:0] sub_w;
  logic [63:0] sub_d;
  logic [63:0] sat_b;
  logic [63:0] sat_w;
  logic [63:0] next_result;
  pss_pkg::pss_fault_t next_fault;
  logic [32:0] last_byte_addr;
  logic emu;
  logic tsw;
  logic fpe;
  logic prot;
  logic [1:0] cpl;
  logic apb_access;
  logic apb_commit;
  logic [31:0] next_prdata;
  logic next_slverr;

  assign emu = ctrl[`PSS_CTRL_EMU];
  assign tsw = ctrl[`PSS_CTRL_TSW];
  assign fpe = ctrl[`PSS_CTRL_FPE];
  assign prot = ctrl[`PSS_CTRL_PROT];
  assign cpl = ctrl[`PSS_CTRL_CPL_HI:`PSS_CTRL_CPL_LO];

  // Decode
  always_comb begin
    op = pss_pkg::PSS_OP_BAD;
    imm_form = 1'b0;
    case (I_REQ.opcode)
      `PSS_OPC_SHRW_RM: op = pss_pkg::PSS_OP_SHRW;
      `PSS_OPC_SHRD_RM: op = pss_pkg::PSS_OP_SHRD;
      `PSS_OPC_SHRQ_RM: op = pss_pkg::PSS_OP_SHRQ;
      `PSS_OPC_SHRW_IMM: begin
        imm_form = 1'b1;
        if (I_REQ.modrm_reg == `PSS_MODRM_SHR) begin
          op = pss_pkg::PSS_OP_SHRW;
        end
      end
      `PSS_OPC_SHRD_IMM: begin
        imm_form = 1'b1;
        if (I_REQ.modrm_reg == `PSS_MODRM_SHR) begin
          op = pss_pkg::PSS_OP_SHRD;
        end
      end
      `PSS_OPC_SHRQ_IMM: begin
        imm_form = 1'b1;
        if (I_REQ.modrm_reg == `PSS_MODRM_SHR) begin
          op = pss_pkg::PSS_OP_SHRQ;
        end
      end
      `PSS_OPC_SUBB: op = pss_pkg::PSS_OP_SUBB;
      `PSS_OPC_SUBW: op = pss_pkg::PSS_OP_SUBW;
      `PSS_OPC_SUBD: op = pss_pkg::PSS_OP_SUBD;
      `PSS_OPC_SATB: op = pss_pkg::PSS_OP_SATB;
      `PSS_OPC_SATW: op = pss_pkg::PSS_OP_SATW;
      default: op = pss_pkg::PSS_OP_BAD;
    endcase
  end

  // Immediate forms never touch memory, so the count source follows the opcode
  assign count = imm_form ? {56'h0, I_REQ.imm8} : I_REQ.src;

  // Whole count compared, so upper garbage bits cannot alias a small shift
  assign zero_w = count > `PSS_LIM_W;
  assign zero_d = count > `PSS_LIM_D;
  assign zero_q = count > `PSS_LIM_Q;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_word
      logic signed [16:0] diff_w;
      assign shr_w[gi*16 +: 16] = zero_w ? 16'h0000 :
        (I_REQ.dst[gi*16 +: 16] >> count[3:0]);
      assign sub_w[gi*16 +: 16] =
        I_REQ.dst[gi*16 +: 16] - I_REQ.src[gi*16 +: 16];
      assign diff_w = $signed({I_REQ.dst[gi*16 + 15], I_REQ.dst[gi*16 +: 16]}) -
        $signed({I_REQ.src[gi*16 + 15], I_REQ.src[gi*16 +: 16]});
      // Sign and carry-out disagree only on overflow
      assign sat_w[gi*16 +: 16] = (diff_w[16] == diff_w[15]) ? diff_w[15:0] :
        (diff_w[16] ? `PSS_SATW_MIN : `PSS_SATW_MAX);
    end
    for (gi = 0; gi < 8; gi++) begin : g_byte
      logic signed [8:0] diff_b;
      assign sub_b[gi*8 +: 8] =
        I_REQ.dst[gi*8 +: 8] - I_REQ.src[gi*8 +: 8];
      assign diff_b = $signed({I_REQ.dst[gi*8 + 7], I_REQ.dst[gi*8 +: 8]}) -
        $signed({I_REQ.src[gi*8 + 7], I_REQ.src[gi*8 +: 8]});
      assign sat_b[gi*8 +: 8] = (diff_b[8] == diff_b[7]) ? diff_b[7:0] :
        (diff_b[8] ? `PSS_SATB_MIN : `PSS_SATB_MAX);
    end
    for (gi = 0; gi < 2; gi++) begin : g_dword
      assign shr_d[gi*32 +: 32] = zero_d ? 32'h0000_0000 :
        (I_REQ.dst[gi*32 +: 32] >> count[4:0]);
      assign sub_d[gi*32 +: 32] =
        I_REQ.dst[gi*32 +: 32] - I_REQ.src[gi*32 +: 32];
    end
  endgenerate

  assign shr_q = zero_q ? 64'h0 : (I_REQ.dst >> count[5:0]);

  // Result select
  always_comb begin
    case (op)
      pss_pkg::PSS_OP_SHRW: next_result = shr_w;
      pss_pkg::PSS_OP_SHRD: next_result = shr_d;
      pss_pkg::PSS_OP_SHRQ: next_result = shr_q;
      pss_pkg::PSS_OP_SUBB: next_result = sub_b;
      pss_pkg::PSS_OP_SUBW: next_result = sub_w;
      pss_pkg::PSS_OP_SUBD: next_result = sub_d;
      pss_pkg::PSS_OP_SATB: next_result = sat_b;
      pss_pkg::PSS_OP_SATW: next_result = sat_w;
      default: next_result = 64'h0;
    endcase
  end

  assign last_byte_addr = {1'b0, I_REQ.mem_addr} + `PSS_OPND_LAST;

  // Fault priority: opcode, device, float, then memory checks
  always_comb begin
    next_fault = pss_pkg::PSS_FLT_NONE;
    if (op == pss_pkg::PSS_OP_BAD || emu) begin
      next_fault = pss_pkg::PSS_FLT_UD;
    end else if (tsw) begin
      next_fault = pss_pkg::PSS_FLT_NM;
    end else if (fpe) begin
      next_fault = pss_pkg::PSS_FLT_MF;
    end else if (I_REQ.src_is_mem && !imm_form) begin
      if (prot) begin
        if (I_REQ.mem_gp) begin
          next_fault = pss_pkg::PSS_FLT_GP;
        end else if (I_REQ.mem_ss) begin
          next_fault = pss_pkg::PSS_FLT_SS;
        end else if (I_REQ.mem_pf) begin
          next_fault = pss_pkg::PSS_FLT_PF;
        end else if (cpl == `PSS_CPL_USER &&
                     (I_REQ.mem_addr & `PSS_ALIGN_MASK) != 32'h0) begin
          next_fault = pss_pkg::PSS_FLT_AC;
        end
      end else if (last_byte_addr > `PSS_REAL_TOP) begin
        next_fault = pss_pkg::PSS_FLT_GP;
      end
    end
  end

  // Response; there is no flag output at all, so flags stay untouched
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_RSP <= '0;
    end else begin
      O_RSP.valid <= I_REQ.valid;
      O_RSP.fault <= I_REQ.valid && next_fault != pss_pkg::PSS_FLT_NONE;
      O_RSP.fault_code <= I_REQ.valid ? next_fault : pss_pkg::PSS_FLT_NONE;
      if (I_REQ.valid && next_fault == pss_pkg::PSS_FLT_NONE) begin
        O_RSP.dst_write <= 1'b1;
        O_RSP.result <= next_result;
      end else begin
        O_RSP.dst_write <= 1'b0;
        O_RSP.result <= 64'h0;
      end
    end
  end

  // Statistics and last fault, visible to software
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      op_count <= 32'h0;
      fault_count <= 32'h0;
      last_fault <= pss_pkg::PSS_FLT_NONE;
    end else if (I_REQ.valid) begin
      last_fault <= next_fault;
      if (next_fault == pss_pkg::PSS_FLT_NONE) begin
        op_count <= op_count + 32'h1;
      end else begin
        fault_count <= fault_count + 32'h1;
      end
    end
  end

  // APB: one wait state so that pready can come from a flop
  assign apb_access = I_PSEL && I_PENABLE;
  assign apb_commit = apb_access && O_PREADY;

  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl <= `PSS_CTRL_RST;
    end else if (apb_commit && I_PWRITE && I_PADDR == `PSS_CTRL_OFS && I_PSTRB[0]) begin
      ctrl <= I_PWDATA[5:0];
    end
  end

  always_comb begin
    next_prdata = 32'h0;
    next_slverr = 1'b0;
    case (I_PADDR)
      `PSS_CTRL_OFS: next_prdata = {26'h0, ctrl};
      `PSS_STAT_OFS: next_prdata = {29'h0, last_fault};
      `PSS_OPCNT_OFS: next_prdata = op_count;
      `PSS_FLTCNT_OFS: next_prdata = fault_count;
      default: next_slverr = 1'b1;
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_PREADY <= 1'b0;
      O_PRDATA <= 32'h0;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY <= apb_access && !O_PREADY;
      O_PSLVERR <= apb_access && !O_PREADY && next_slverr;
      O_PRDATA <= (apb_access && !O_PREADY && !I_PWRITE) ? next_prdata : 32'h0;
    end
  end

endmodule
`default_nettype wire

// ---- tb/pss_dec_model.sv ----
// Decode-side model presenting one instruction request per call
`default_nettype none
module pss_dec_model (
  // Clock
  input wire logic i_clk,
  // Request to the unit
  output var pss_pkg::pss_req_t o_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_req = '0;
  // Operand from register, memory or immediate
  task automatic issue(input logic [7:0] opc, input logic [2:0] mr, input logic [7:0] imm,
    input logic [63:0] d, input logic [63:0] s, input logic mem, input logic [31:0] a,
    input logic [2:0] mf);
    pss_pkg::pss_req_t r;
    @(posedge i_clk);
    o_req <= {1'h1, opc, mr, imm, d, s, mem, a, mf};
    @(posedge i_clk);
    // Stale fields show their inverse so nothing leans on held values
    r = ~o_req;
    r.valid = 1'h0;
    o_req <= r;
  endtask
endmodule
`default_nettype wire

// ---- tb/pss_unit_bench.sv ----
// Self-checking bench for the packed shift/subtract unit
`include "pss_map.svh"
`default_nettype none
module pss_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata, q;
  logic pready, pslverr, e;
  pss_pkg::pss_req_t req;
  pss_pkg::pss_rsp_t rsp;
  int n_fail = 0;
  int n_tests = 0;
  int n_ok = 0;
  int n_bad = 0;
  always #2 clk = ~clk;
  pss_unit dut_u (.I_MCLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_REQ(req), .O_RSP(rsp));
  pss_dec_model dec_u (.i_clk(clk), .o_req(req));
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] g);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // Look between edges so ready and data are settled, not racing their launch
    do begin
      @(negedge clk);
      k++;
    end while (pready !== 1'h1 && k < 16);
    if (k >= 16) n_fail++;
    q = prdata;
    e = pslverr;
    // Commit edge: ready is sampled high here, then the request is released
    @(posedge clk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  function automatic logic [63:0] shr(input int w, input logic [63:0] d, input logic [63:0] c);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < 64; i++)
      if (c < w && i % w + c < w) r[i] = d[i + c];
    return r;
  endfunction
  function automatic logic [63:0] sbx(input int w, input bit sat, input logic [63:0] d,
    input logic [63:0] s);
    logic [63:0] r;
    longint m, a, b;
    r = '0;
    m = (longint'(1) << w) - 1;
    for (int i = 0; i < 64; i += w) begin
      a = longint'((d >> i) & m);
      b = longint'((s >> i) & m);
      if (sat) begin
        a = a > m / 2 ? a - m - 1 : a;
        b = b > m / 2 ? b - m - 1 : b;
      end
      a = a - b;
      if (sat) a = a > m / 2 ? m / 2 : a < -m / 2 - 1 ? -m / 2 - 1 : a;
      r = r | (64'(a & m) << i);
    end
    return r;
  endfunction
  // Low opcode bit picks memory or register source, so both paths run
  task automatic op(input logic [7:0] o, input logic [7:0] i, input logic [63:0] d,
    input logic [63:0] s, input logic [63:0] x);
    dec_u.issue(o, `PSS_MODRM_SHR, i, d, s, o[0], 32'h0, 3'h0);
    #1;
    n_ok++;
    chk("valid", 64'h1, 64'(rsp.valid));
    chk("result", x, rsp.result);
    chk("write", 64'h1, 64'(rsp.dst_write));
  endtask
  task automatic fchk(input logic [7:0] o, input logic [7:0] ctl, input logic [2:0] mf,
    input logic [31:0] a, input pss_pkg::pss_fault_t x);
    apb(1'h1, `PSS_CTRL_OFS, {24'h0, ctl});
    dec_u.issue(o, 3'h0, 8'h0, 64'h5, 64'h3, 1'h1, a, mf);
    #1;
    chk("code", 64'(x), 64'(rsp.fault_code));
    chk("fault", 64'(x != pss_pkg::PSS_FLT_NONE), 64'(rsp.fault));
    chk("fwrite", 64'(x == pss_pkg::PSS_FLT_NONE), 64'(rsp.dst_write));
    apb(1'h0, `PSS_STAT_OFS, 32'h0);
    chk("stat", 64'(x), 64'(q[2:0]));
    if (x == pss_pkg::PSS_FLT_NONE) n_ok++;
    else n_bad++;
  endtask
  task automatic t_regs;
    apb(1'h0, `PSS_CTRL_OFS, 32'h0);
    chk("ctrl", 64'h0, 64'(q));
    apb(1'h0, 12'h010, 32'h0);
    chk("unmapped", 64'h1_0000_0000, {31'h0, e, q});
    pstrb <= 4'hE;
    apb(1'h1, `PSS_CTRL_OFS, 32'h3F);
    pstrb <= 4'hF;
    apb(1'h1, `PSS_OPCNT_OFS, 32'h55);
    apb(1'h0, `PSS_CTRL_OFS, 32'h0);
    chk("strobe", 64'h0, 64'(q));
    apb(1'h0, `PSS_OPCNT_OFS, 32'h0);
    chk("ro", 64'h0, 64'(q));
    $display("done regs");
  endtask
  task automatic t_shift;
    logic [63:0] c[9] = '{64'h0, 64'h1, 64'hF, 64'h10, 64'h1F, 64'h20, 64'h3F, 64'h40,
      64'h1_0000_0004};
    logic [63:0] d;
    d = 64'hF0E1_D2C3_B4A5_9687;
    foreach (c[j]) begin
      for (int k = 0; k < 3; k++) begin
        op(8'hD1 + 8'(k), 8'h0, d, c[j], shr(16 << k, d, c[j]));
        op(8'h71 + 8'(k), c[j][7:0], d, ~c[j], shr(16 << k, d, 64'(c[j][7:0])));
      end
    end
    $display("done shift");
  endtask
  task automatic t_sub;
    logic [63:0] a, b;
    for (int r = 0; r < 2; r++) begin
      a = r ? 64'h8001_7FFF_0180_8001 : 64'h7F80_0001_FF7F_7FFF;
      b = r ? 64'h7F80_0001_FF7F_7FFF : 64'h8001_7FFF_0180_8001;
      for (int k = 0; k < 3; k++) begin
        op(8'hF8 + 8'(k), 8'h0, a, b, sbx(8 << k, 1'b0, a, b));
        if (k < 2) op(8'hE8 + 8'(k), 8'h0, a, b, sbx(8 << k, 1'b1, a, b));
      end
    end
    $display("done sub");
  endtask
  task automatic t_fault;
    fchk(8'hF8, 8'h01, 3'h0, 32'h0, pss_pkg::PSS_FLT_UD);
    fchk(8'hF8, 8'h07, 3'h0, 32'h0, pss_pkg::PSS_FLT_UD);
    fchk(8'hF8, 8'h02, 3'h0, 32'h0, pss_pkg::PSS_FLT_NM);
    fchk(8'hF8, 8'h04, 3'h0, 32'h0, pss_pkg::PSS_FLT_MF);
    fchk(8'hF8, 8'h08, 3'h4, 32'h0, pss_pkg::PSS_FLT_GP);
    fchk(8'hF8, 8'h08, 3'h2, 32'h0, pss_pkg::PSS_FLT_SS);
    fchk(8'hF8, 8'h08, 3'h1, 32'h0, pss_pkg::PSS_FLT_PF);
    fchk(8'hF8, 8'h38, 3'h0, 32'h1, pss_pkg::PSS_FLT_AC);
    fchk(8'hF8, 8'h38, 3'h0, 32'h8, pss_pkg::PSS_FLT_NONE);
    fchk(8'hF8, 8'h00, 3'h0, 32'hFFF9, pss_pkg::PSS_FLT_GP);
    fchk(8'hF8, 8'h00, 3'h0, 32'hFFF8, pss_pkg::PSS_FLT_NONE);
    fchk(8'h71, 8'h00, 3'h0, 32'h0, pss_pkg::PSS_FLT_UD);
    apb(1'h0, `PSS_OPCNT_OFS, 32'h0);
    chk("opcnt", 64'(n_ok), 64'(q));
    apb(1'h0, `PSS_FLTCNT_OFS, 32'h0);
    chk("fltcnt", 64'(n_bad), 64'(q));
    $display("done fault");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    t_regs();
    t_shift();
    t_sub();
    t_fault();
    conclude();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire

// ---- tb/pss_unit_checker.sv ----
// Port assertions for the packed shift/subtract unit
`include "pss_map.svh"
`default_nettype none
module pss_unit_checker (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  // APB side
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic O_PREADY,
  // Instruction side
  input wire pss_pkg::pss_req_t I_REQ,
  input wire pss_pkg::pss_rsp_t O_RSP
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_B);
  a_rsp_one_late: assert property (I_REQ.valid |=> O_RSP.valid)
    else $error("answer missing");
  a_no_stray: assert property (!I_REQ.valid |=> !O_RSP.valid && !O_RSP.dst_write)
    else $error("answer without request");
  a_fault_no_write: assert property (O_RSP.fault |-> !O_RSP.dst_write && !O_RSP.result)
    else $error("faulting op wrote");
  a_qshift_value: assert property (I_REQ.valid && I_REQ.opcode == `PSS_OPC_SHRQ_RM |=>
    O_RSP.fault || O_RSP.result == ($past(I_REQ.src) > `PSS_LIM_Q ? 64'h0 :
    $past(I_REQ.dst) >> $past(I_REQ.src))) else $error("quad shift wrong");
  a_subb_top: assert property (I_REQ.valid && I_REQ.opcode == `PSS_OPC_SUBB |=>
    O_RSP.fault || O_RSP.result[63:56] == 8'($past(I_REQ.dst) >> 56) -
    8'($past(I_REQ.src) >> 56)) else $error("byte wrap wrong");
  a_satw_high: assert property (I_REQ.valid && I_REQ.opcode == `PSS_OPC_SATW &&
    I_REQ.dst[15:0] == 16'h7FFF && I_REQ.src[15] |=>
    O_RSP.fault || O_RSP.result[15:0] == `PSS_SATW_MAX) else $error("word clamp wrong");
  a_imm_word: assert property (I_REQ.valid && I_REQ.opcode == `PSS_OPC_SHRW_IMM &&
    I_REQ.modrm_reg == `PSS_MODRM_SHR |=> O_RSP.fault || O_RSP.result[15:0] ==
    ($past(I_REQ.imm8) > 8'hF ? 16'h0 : 16'($past(I_REQ.dst)) >> $past(I_REQ.imm8)))
    else $error("immediate shift wrong");
  a_one_wait: assert property (I_PSEL && I_PENABLE && !$past(I_PENABLE) |->
    !O_PREADY ##1 O_PREADY) else $error("ready timing wrong");
  c_fault: cover property (O_RSP.fault);
  c_write: cover property (O_RSP.dst_write);
  c_align: cover property (O_RSP.fault_code == pss_pkg::PSS_FLT_AC);
endmodule
bind pss_unit pss_unit_checker chk_u (.I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .O_PREADY(O_PREADY), .I_REQ(I_REQ), .O_RSP(O_RSP));
`default_nettype wire
